//--- core/ccl_pkg.sv
// comparator control logic: register map, field positions, reset values, types
// assumes an 8-bit register port and a single 200 MHz system clock
package ccl_pkg;

    // register offsets on the byte-wide register port
    localparam logic [7:0] CCL_ADDR_CTRL_STATUS = 8'h50;
    localparam logic [7:0] CCL_ADDR_CONV_CTRL_B = 8'h7B;
    localparam logic [7:0] CCL_ADDR_BUF_DISABLE = 8'h7F;

    // comparator control/status fields
    localparam int CCL_BIT_POWER_OFF = 7;
    localparam int CCL_BIT_BANDGAP_SEL = 6;
    localparam int CCL_BIT_RESULT = 5;
    localparam int CCL_BIT_EVENT_FLAG = 4;
    localparam int CCL_BIT_INT_ENABLE = 3;
    localparam int CCL_BIT_CAPTURE_ROUTE = 2;
    localparam int CCL_BIT_MODE_HI = 1;
    localparam int CCL_BIT_MODE_LO = 0;

    // converter control b fields
    localparam int CCL_BIT_MUX_NEG_EN = 6;
    localparam int CCL_BIT_TRIG_HI = 2;
    localparam int CCL_BIT_TRIG_LO = 0;

    // input buffer disable fields
    localparam int CCL_BIT_NEG_BUF_DIS = 1;
    localparam int CCL_BIT_POS_BUF_DIS = 0;

    // reset values
    localparam logic [7:0] CCL_RST_BYTE = 8'h00;
    localparam logic [2:0] CCL_RST_TRIG = 3'h0;
    localparam logic [2:0] CCL_RST_CHANNEL = 3'h0;
    localparam logic CCL_RST_BIT = 1'b0;

    // synchroniser depth: result lags the raw comparator by 1 to 2 cycles
    localparam int CCL_SYNC_LAT_MIN = 1;
    localparam int CCL_SYNC_LAT_MAX = 2;

    typedef enum logic [1:0] {
        CCL_MODE_TOGGLE = 2'b00,
        CCL_MODE_RESERVED = 2'b01,
        CCL_MODE_FALL = 2'b10,
        CCL_MODE_RISE = 2'b11
    } ccl_mode_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ccl_bus_req_s;

    typedef struct packed {
        logic power_off;
        logic bandgap_sel;
        logic int_enable;
        logic capture_route;
        ccl_mode_e mode;
        logic mux_neg_en;
        logic [2:0] trig_src;
        logic neg_buf_dis;
        logic pos_buf_dis;
    } ccl_ctrl_s;

endpackage : ccl_pkg

//--- core/ccl_top.sv
// comparator control logic: input selection, result synchroniser, event flag,
// interrupt request, capture routing and pin input buffer disables
// assumes the analog core, converter and timer capture unit sit outside;
// all inputs are synchronous to clk except comparator_raw, which is synchronised here
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps

module ccl_top
    import ccl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire ccl_bus_req_s bus_req,
    output logic [7:0] bus_rdata,
    input wire logic comparator_raw,
    input wire logic converter_enable,
    input wire logic [2:0] channel_select_field,
    input wire logic global_int_enable,
    input wire logic vector_ack,
    input wire logic positive_input_pin,
    input wire logic negative_input_pin,
    output logic sel_bandgap_positive,
    output logic sel_channel_negative,
    output logic [2:0] sel_channel_index,
    output logic comparator_power_off,
    output logic compare_irq,
    output logic capture_trigger,
    output logic [2:0] trigger_source,
    output logic positive_pin_read,
    output logic negative_pin_read,
    output logic positive_pin_buffer_off,
    output logic negative_pin_buffer_off
);

    ccl_ctrl_s ctrl_ff;
    logic sync1_ff;
    logic result_ff;
    logic result_prev_ff;
    logic flag_ff;
    logic nxt_flag;
    logic rise;
    logic fall;
    logic event_hit;
    logic flag_clear;
    logic [7:0] rdata_ff;
    logic irq_ff;
    logic nxt_int_enable;
    logic capture_ff;
    logic sel_bg_ff;
    logic sel_mux_ff;
    logic [2:0] sel_idx_ff;
    logic pos_read_ff;
    logic neg_read_ff;
    logic wr_ctrl;
    logic wr_convb;
    logic wr_bufdis;

    assign wr_ctrl = bus_req.wr && (bus_req.addr == CCL_ADDR_CTRL_STATUS);
    assign wr_convb = bus_req.wr && (bus_req.addr == CCL_ADDR_CONV_CTRL_B);
    assign wr_bufdis = bus_req.wr && (bus_req.addr == CCL_ADDR_BUF_DISABLE);

    // software control fields
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_ff.power_off <= CCL_RST_BIT;
            ctrl_ff.bandgap_sel <= CCL_RST_BIT;
            ctrl_ff.int_enable <= CCL_RST_BIT;
            ctrl_ff.capture_route <= CCL_RST_BIT;
            ctrl_ff.mode <= CCL_MODE_TOGGLE;
            ctrl_ff.mux_neg_en <= CCL_RST_BIT;
            ctrl_ff.trig_src <= CCL_RST_TRIG;
            ctrl_ff.neg_buf_dis <= CCL_RST_BIT;
            ctrl_ff.pos_buf_dis <= CCL_RST_BIT;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff.power_off <= bus_req.wdata[CCL_BIT_POWER_OFF];
                ctrl_ff.bandgap_sel <= bus_req.wdata[CCL_BIT_BANDGAP_SEL];
                ctrl_ff.int_enable <= bus_req.wdata[CCL_BIT_INT_ENABLE];
                ctrl_ff.capture_route <= bus_req.wdata[CCL_BIT_CAPTURE_ROUTE];
                ctrl_ff.mode <= ccl_mode_e'(bus_req.wdata[CCL_BIT_MODE_HI:CCL_BIT_MODE_LO]);
            end
            if (wr_convb) begin
                ctrl_ff.mux_neg_en <= bus_req.wdata[CCL_BIT_MUX_NEG_EN];
                ctrl_ff.trig_src <= bus_req.wdata[CCL_BIT_TRIG_HI:CCL_BIT_TRIG_LO];
            end
            if (wr_bufdis) begin
                ctrl_ff.neg_buf_dis <= bus_req.wdata[CCL_BIT_NEG_BUF_DIS];
                ctrl_ff.pos_buf_dis <= bus_req.wdata[CCL_BIT_POS_BUF_DIS];
            end
        end
    end

    // two-stage synchroniser on the analog output
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_ff <= CCL_RST_BIT;
            result_ff <= CCL_RST_BIT;
            result_prev_ff <= CCL_RST_BIT;
        end else begin
            sync1_ff <= comparator_raw;
            result_ff <= sync1_ff;
            result_prev_ff <= result_ff;
        end
    end

    assign rise = result_ff && !result_prev_ff;
    assign fall = !result_ff && result_prev_ff;

    always_comb begin
        case (ctrl_ff.mode)
            CCL_MODE_TOGGLE: event_hit = rise || fall;
            CCL_MODE_FALL: event_hit = fall;
            CCL_MODE_RISE: event_hit = rise;
            CCL_MODE_RESERVED: event_hit = 1'b0;
            default: event_hit = 1'b0;
        endcase
    end

    assign flag_clear = vector_ack || (wr_ctrl && bus_req.wdata[CCL_BIT_EVENT_FLAG]);

    // a new event wins over a clear in the same cycle
    always_comb begin
        nxt_flag = flag_ff;
        if (flag_clear) begin
            nxt_flag = 1'b0;
        end
        if (event_hit) begin
            nxt_flag = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag_ff <= CCL_RST_BIT;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    // enable write reaches the irq at once, so clearing it leaves no stray cycle
    always_comb begin
        nxt_int_enable = ctrl_ff.int_enable;
        if (wr_ctrl) begin
            nxt_int_enable = bus_req.wdata[CCL_BIT_INT_ENABLE];
        end
    end

    // interrupt request follows the flag and both enables
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_ff <= CCL_RST_BIT;
        end else begin
            irq_ff <= nxt_flag && nxt_int_enable && global_int_enable;
        end
    end

    // capture trigger routing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            capture_ff <= CCL_RST_BIT;
        end else begin
            capture_ff <= ctrl_ff.capture_route && result_ff ? 1'b1 : 1'b0;
        end
    end

    // analog input selection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sel_bg_ff <= CCL_RST_BIT;
            sel_mux_ff <= CCL_RST_BIT;
            sel_idx_ff <= CCL_RST_CHANNEL;
        end else begin
            sel_bg_ff <= ctrl_ff.bandgap_sel;
            sel_mux_ff <= ctrl_ff.mux_neg_en && !converter_enable;
            sel_idx_ff <= (ctrl_ff.mux_neg_en && !converter_enable) ? channel_select_field : CCL_RST_CHANNEL;
        end
    end

    // pin reads gated by the buffer disables
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pos_read_ff <= CCL_RST_BIT;
            neg_read_ff <= CCL_RST_BIT;
        end else begin
            pos_read_ff <= positive_input_pin && !ctrl_ff.pos_buf_dis;
            neg_read_ff <= negative_input_pin && !ctrl_ff.neg_buf_dis;
        end
    end

    // read port: data stands one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_ff <= CCL_RST_BYTE;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                CCL_ADDR_CTRL_STATUS: begin
                    rdata_ff <= {ctrl_ff.power_off, ctrl_ff.bandgap_sel, result_ff, flag_ff,
                                 ctrl_ff.int_enable, ctrl_ff.capture_route, ctrl_ff.mode};
                end
                CCL_ADDR_CONV_CTRL_B: begin
                    rdata_ff <= {1'b0, ctrl_ff.mux_neg_en, 3'h0, ctrl_ff.trig_src};
                end
                CCL_ADDR_BUF_DISABLE: begin
                    rdata_ff <= {6'h00, ctrl_ff.neg_buf_dis, ctrl_ff.pos_buf_dis};
                end
                default: begin
                    rdata_ff <= CCL_RST_BYTE;
                end
            endcase
        end
    end

    assign bus_rdata = rdata_ff;
    assign compare_irq = irq_ff;
    assign capture_trigger = capture_ff;
    assign comparator_power_off = ctrl_ff.power_off;
    assign sel_bandgap_positive = sel_bg_ff;
    assign sel_channel_negative = sel_mux_ff;
    assign sel_channel_index = sel_idx_ff;
    assign trigger_source = ctrl_ff.trig_src;
    assign positive_pin_read = pos_read_ff;
    assign negative_pin_read = neg_read_ff;
    assign positive_pin_buffer_off = ctrl_ff.pos_buf_dis;
    assign negative_pin_buffer_off = ctrl_ff.neg_buf_dis;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_raw_held;
        comparator_raw [*2];
    endsequence

    sequence s_result_high;
        ##1 result_ff;
    endsequence

    property p_sync_latency;
        s_raw_held |-> s_result_high;
    endproperty
    a_sync_latency: assert property (p_sync_latency) else $error("result not high after raw held");

    property p_result_not_early;
        !comparator_raw ##1 !comparator_raw |-> ##1 !result_ff;
    endproperty
    a_result_not_early: assert property (p_result_not_early) else $error("result high without raw");

    property p_flag_on_rise;
        (ctrl_ff.mode == CCL_MODE_RISE) && rise |=> flag_ff;
    endproperty
    a_flag_on_rise: assert property (p_flag_on_rise) else $error("rising event did not set flag");

    property p_reserved_no_set;
        (ctrl_ff.mode == CCL_MODE_RESERVED) && !flag_ff |=> !flag_ff;
    endproperty
    a_reserved_no_set: assert property (p_reserved_no_set) else $error("reserved mode set flag");

    property p_ack_clears;
        vector_ack && !event_hit |=> !flag_ff;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("vector ack did not clear flag");

    property p_write_zero_keeps;
        flag_ff && wr_ctrl && !bus_req.wdata[CCL_BIT_EVENT_FLAG] && !vector_ack |=> flag_ff;
    endproperty
    a_write_zero_keeps: assert property (p_write_zero_keeps) else $error("writing zero cleared flag");

    property p_irq_gated;
        compare_irq |-> flag_ff && $past(global_int_enable) && ctrl_ff.int_enable;
    endproperty
    a_irq_gated: assert property (p_irq_gated) else $error("irq without flag and enables");

    property p_capture_off;
        !ctrl_ff.capture_route ##1 !ctrl_ff.capture_route |-> !capture_trigger;
    endproperty
    a_capture_off: assert property (p_capture_off) else $error("capture trigger while unrouted");

    property p_buf_read_zero;
        ctrl_ff.pos_buf_dis ##1 ctrl_ff.pos_buf_dis |-> !positive_pin_read;
    endproperty
    a_buf_read_zero: assert property (p_buf_read_zero) else $error("disabled pin read nonzero");

    property p_mux_sel;
        ctrl_ff.mux_neg_en && !converter_enable |=> sel_channel_negative && sel_channel_index == $past(channel_select_field);
    endproperty
    a_mux_sel: assert property (p_mux_sel) else $error("channel mux not selected");

    property p_pin_sel;
        !ctrl_ff.mux_neg_en || converter_enable |=> !sel_channel_negative;
    endproperty
    a_pin_sel: assert property (p_pin_sel) else $error("negative pin not selected");

    property p_reserved_read;
        bus_req.rd && bus_req.addr == CCL_ADDR_BUF_DISABLE |=> bus_rdata[7:2] == 6'h00;
    endproperty
    a_reserved_read: assert property (p_reserved_read) else $error("unused bits read nonzero");

endmodule : ccl_top

//--- tb/ccl_analog_model.sv
// behavioural analog comparator core facing the control block
// assumes voltages are 8-bit codes driven by the testbench
`timescale 1ns/100ps

module ccl_analog_model (
    input wire logic sel_bandgap_positive,
    input wire logic sel_channel_negative,
    input wire logic [2:0] sel_channel_index,
    input wire logic comparator_power_off,
    input wire logic [7:0] pos_level,
    input wire logic [7:0] neg_level,
    input wire logic [63:0] chan_levels,
    input wire logic [7:0] bandgap_level,
    input wire logic converter_power_reduction,
    input wire logic capture_trigger,
    input wire logic capture_interrupt_enable,
    output logic comparator_raw,
    output logic capture_irq
);
    logic [7:0] pos_sel;
    logic [7:0] neg_sel;

    assign pos_sel = sel_bandgap_positive ? bandgap_level : pos_level;
    // converter mux unusable while its power reduction is set
    assign neg_sel = sel_channel_negative ? (converter_power_reduction ? 8'hFF : chan_levels[sel_channel_index*8 +: 8])
                                          : neg_level;
    // timer capture interrupt needs its own enable as well
    assign capture_irq = capture_trigger && capture_interrupt_enable;
    // unpowered core gives a low output
    assign comparator_raw = !comparator_power_off && (pos_sel > neg_sel);
endmodule : ccl_analog_model

//--- tb/testbench.sv
// self-checking bench for the comparator control block
// assumes the analog model in ccl_analog_model.sv drives the raw result
`timescale 1ns/100ps

module testbench
    import ccl_pkg::*;
;
    logic clk, rst_n, converter_enable, global_int_enable, vector_ack;
    logic positive_input_pin, negative_input_pin, comparator_raw, rd_d, exp_f;
    logic sel_bandgap_positive, sel_channel_negative, comparator_power_off, compare_irq, capture_trigger;
    logic positive_pin_read, negative_pin_read, positive_pin_buffer_off, negative_pin_buffer_off;
    logic converter_power_reduction, capture_interrupt_enable, capture_irq;
    logic [2:0] channel_select_field, sel_channel_index, trigger_source;
    logic [7:0] bus_rdata, pos_level, neg_level, bandgap_level;
    logic [63:0] chan_levels;
    logic [7:0] exp_q[$];
    ccl_bus_req_s bus_req;
    int fails, tests_run;
    integer seed;

    ccl_top i_dut (.clk, .rst_n, .bus_req, .bus_rdata, .comparator_raw, .converter_enable,
        .channel_select_field, .global_int_enable, .vector_ack, .positive_input_pin, .negative_input_pin,
        .sel_bandgap_positive, .sel_channel_negative, .sel_channel_index, .comparator_power_off,
        .compare_irq, .capture_trigger, .trigger_source, .positive_pin_read, .negative_pin_read,
        .positive_pin_buffer_off, .negative_pin_buffer_off);

    ccl_analog_model i_model (.sel_bandgap_positive, .sel_channel_negative, .sel_channel_index,
        .comparator_power_off, .pos_level, .neg_level, .chan_levels, .bandgap_level, .comparator_raw,
        .converter_power_reduction, .capture_trigger, .capture_interrupt_enable, .capture_irq);

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) rd_d <= bus_req.rd;

    // read data is checked in the cycle after the strobe; it holds until the next read
    always @(negedge clk) begin
        if (rd_d === 1'b1 && exp_q.size() > 0)
            check("rdata", bus_rdata, exp_q.pop_front());
    end

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        tally_and_finish();
    end

    initial begin
        seed = 32'hA1A5;
        fails = 0;
        tests_run = 0;
        rst_n = 1'b0;
        bus_req = '0;
        converter_enable = 1'b0;
        channel_select_field = 3'h0;
        global_int_enable = 1'b1;
        vector_ack = 1'b0;
        {positive_input_pin, negative_input_pin} = 2'b11;
        pos_level = 8'h32;
        neg_level = 8'h64;
        bandgap_level = 8'h80;
        chan_levels = '0;
        converter_power_reduction = 1'b0;
        capture_interrupt_enable = 1'b1;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        settle(1);
        check("rst_out", {1'b0, sel_bandgap_positive, sel_channel_negative, comparator_power_off, compare_irq,
            capture_trigger, positive_pin_buffer_off, negative_pin_buffer_off}, 8'h00);
        check("rst_trig", trigger_source, 8'h00);
        rd(CCL_ADDR_CTRL_STATUS, 8'h00);
        rd(CCL_ADDR_CONV_CTRL_B, 8'h00);
        rd(CCL_ADDR_BUF_DISABLE, 8'h00);
        rd(8'h33, 8'h00);
        wr(CCL_ADDR_CONV_CTRL_B, 8'hFF);
        rd(CCL_ADDR_CONV_CTRL_B, 8'h47);
        check("trig_src", trigger_source, 8'h07);
        wr(CCL_ADDR_BUF_DISABLE, 8'hFF);
        rd(CCL_ADDR_BUF_DISABLE, 8'h03);
        for (int i = 0; i < 8; i++) begin
            if (i == 4)
                wr(CCL_ADDR_BUF_DISABLE, 8'h00);
            @(posedge clk);
            {positive_input_pin, negative_input_pin} <= 2'($random(seed));
            settle(2);
            check("pos_read", positive_pin_read, i < 4 ? 1'b0 : positive_input_pin);
            check("neg_read", negative_pin_read, i < 4 ? 1'b0 : negative_input_pin);
            check("buf_off", {positive_pin_buffer_off, negative_pin_buffer_off}, i < 4 ? 2'b11 : 2'b00);
        end
        // mode 01 keeps the flag quiet while inputs move
        wr(CCL_ADDR_CTRL_STATUS, 8'h11);
        wr(CCL_ADDR_CONV_CTRL_B, 8'h40);
        for (int c = 0; c < 8; c++) begin
            @(posedge clk);
            channel_select_field <= 3'(c);
            chan_levels[c*8 +: 8] <= 8'($random(seed));
            pos_level <= 8'($random(seed));
            settle(4);
            check("sel_neg", {sel_channel_negative, sel_channel_index}, {1'b1, 3'(c)});
            rd(CCL_ADDR_CTRL_STATUS, {2'b00, pos_level > chan_levels[c*8 +: 8], 5'h01});
        end
        @(posedge clk);
        converter_enable <= 1'b1;
        settle(4);
        check("sel_pin", sel_channel_negative, 1'b0);
        rd(CCL_ADDR_CTRL_STATUS, {2'b00, pos_level > neg_level, 5'h01});
        wr(CCL_ADDR_CTRL_STATUS, 8'h41);
        settle(4);
        check("sel_bg", sel_bandgap_positive, 1'b1);
        rd(CCL_ADDR_CTRL_STATUS, {2'b01, bandgap_level > neg_level, 5'h01});
        @(posedge clk);
        pos_level <= 8'h32;
        wr(CCL_ADDR_CTRL_STATUS, 8'h11);
        for (int m = 0; m < 4; m++) begin
            wr(CCL_ADDR_CTRL_STATUS, 8'h10 | 8'(m));
            wr(CCL_ADDR_CTRL_STATUS, 8'h18 | 8'(m));
            for (int e = 0; e < 2; e++) begin
                @(posedge clk);
                pos_level <= e ? 8'h32 : 8'hC8;
                settle(5);
                exp_f = (m == 0) || (m == 3 - e);
                check("irq", compare_irq, exp_f);
                rd(CCL_ADDR_CTRL_STATUS, {2'b00, 1'(1 - e), exp_f, 2'b10, 2'(m)});
                @(posedge clk);
                global_int_enable <= 1'b0;
                settle(2);
                check("irq_gie", compare_irq, 1'b0);
                @(posedge clk);
                global_int_enable <= 1'b1;
                wr(CCL_ADDR_CTRL_STATUS, 8'h08 | 8'(m));
                settle(2);
                check("irq_w0", compare_irq, exp_f);
                if (e == 0) begin
                    @(posedge clk);
                    vector_ack <= 1'b1;
                    @(posedge clk);
                    vector_ack <= 1'b0;
                end else begin
                    wr(CCL_ADDR_CTRL_STATUS, 8'h18 | 8'(m));
                end
                settle(2);
                check("irq_clr", compare_irq, 1'b0);
            end
        end
        wr(CCL_ADDR_CTRL_STATUS, 8'h13);
        wr(CCL_ADDR_CTRL_STATUS, 8'h05);
        @(posedge clk);
        pos_level <= 8'hC8;
        settle(4);
        check("cap_on", capture_trigger, 1'b1);
        check("cap_irq", capture_irq, 1'b1);
        wr(CCL_ADDR_CTRL_STATUS, 8'h01);
        settle(2);
        check("cap_off", capture_trigger, 1'b0);
        check("cap_irq_off", capture_irq, 1'b0);
        wr(CCL_ADDR_CTRL_STATUS, 8'h81);
        settle(4);
        check("pwr_off", comparator_power_off, 1'b1);
        rd(CCL_ADDR_CTRL_STATUS, 8'h81);
        settle(3);
        tally_and_finish();
    end
endmodule : testbench
